/* File: hw/vt_drop_pkg.sv */
// Purpose: Shared constants for the drop-side VT1.5/TU-11 pointer tracker.
// Assumes: Byte-parallel drop bus, 8-bit register port, one channel per use.
// Notes: Offsets are channel-relative register addresses.
package vt_drop_pkg;
    // Channel register offsets.
    localparam logic [5:0] OFS_SLOT_SELECT = 6'h04;
    localparam logic [5:0] OFS_MASK = 6'h09;
    localparam logic [5:0] OFS_STATUS = 6'h11;
    localparam logic [5:0] OFS_EVENT = 6'h15;
    localparam logic [5:0] OFS_PERF = 6'h19;
    localparam logic [5:0] OFS_FAULT = 6'h1D;
    localparam logic [5:0] OFS_RX_LABEL = 6'h20;
    // Field positions.
    localparam int BIT_SLOT_VALID = 7;
    localparam int BIT_AIS = 5;
    localparam int BIT_LOP = 4;
    localparam int BIT_SIZE_HI = 4;
    localparam int BIT_SIZE_LO = 3;
    localparam logic [7:0] SLOT_SELECT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Slot counts and tributary superframe geometry.
    localparam logic [6:0] SLOTS_LOW = 7'h1C;
    localparam logic [6:0] SLOTS_HIGH = 7'h54;
    localparam logic [6:0] GROUPS_PER_STS = 7'h07;
    localparam logic [6:0] STS_COUNT = 7'h03;
    localparam logic [6:0] SF_LAST_POS = 7'h6B;
    localparam logic [6:0] POS_V1 = 7'h00;
    localparam logic [6:0] POS_V2 = 7'h1B;
    // Pointer word layout and decisions.
    localparam logic [9:0] PTR_MAX = 10'h067;
    localparam logic [9:0] I_MASK = 10'h2AA;
    localparam logic [9:0] D_MASK = 10'h155;
    localparam logic [3:0] VOTE_MIN = 4'h8;
    localparam logic [1:0] SIZE_EXPECTED = 2'h3;
    localparam logic [3:0] NDF_ENABLE = 4'h9;
    localparam logic [3:0] NDF_EN_E1 = 4'h1;
    localparam logic [3:0] NDF_EN_E2 = 4'hD;
    localparam logic [3:0] NDF_EN_E3 = 4'h8;
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    localparam logic [3:0] NDF_NM_E1 = 4'hE;
    localparam logic [3:0] NDF_NM_E2 = 4'h2;
    localparam logic [3:0] NDF_NM_E3 = 4'h4;
    localparam logic [3:0] NDF_NM_E4 = 4'h7;
    // Persistence counts.
    localparam logic [1:0] AIS_COUNT = 2'h3;
    localparam logic [1:0] NEW_COUNT = 2'h3;
    localparam logic [3:0] LOP_COUNT = 4'h8;

    typedef enum logic [1:0] {
        ST_NORM = 2'b00,
        ST_LOP = 2'b01,
        ST_AIS = 2'b10
    } ptr_state_e;
endpackage

/* File: hw/vt_slot_locator.sv */
// Purpose: Finds the selected tributary's bytes and superframe position.
// Assumes: The timing pulse marks the V1 byte of slot 0 of the superframe.
// Notes: Bytes outside the payload envelope are skipped entirely.
`timescale 1ns/10ps
module vt_slot_locator (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic drop_composite_timing,
    input wire logic drop_payload_envelope,
    input wire logic high_rate_select,
    input wire logic enable,
    input wire logic [6:0] slot_select,
    output logic trib_valid,
    output logic [6:0] trib_pos
);
    logic [6:0] slot_cnt_reg;
    logic [6:0] slot_cnt_next;
    logic [6:0] cur_slot;
    logic [6:0] last_slot;
    logic [6:0] target_slot;
    logic [6:0] pos_next;
    logic pend_reg;
    logic hit;
    logic [6:0] sts_num;
    logic [6:0] grp_num;
    logic [6:0] vt_num;

    assign sts_num = {5'h00, slot_select[6:5]};
    assign grp_num = {4'h0, slot_select[4:2]};
    assign vt_num = {5'h00, slot_select[1:0]};
    // Column interleave: STS varies fastest at high rate, then group, then tributary in group.
    assign target_slot = high_rate_select ?
        7'((vt_num * vt_drop_pkg::GROUPS_PER_STS + grp_num)
           * vt_drop_pkg::STS_COUNT + sts_num) :
        7'(vt_num * vt_drop_pkg::GROUPS_PER_STS + grp_num);
    assign last_slot = (high_rate_select ? vt_drop_pkg::SLOTS_HIGH :
        vt_drop_pkg::SLOTS_LOW) - 7'h01;
    assign cur_slot = drop_composite_timing ? 7'h00 : slot_cnt_reg;
    assign slot_cnt_next = (cur_slot >= last_slot) ? 7'h00 :
        cur_slot + 7'h01;
    assign hit = drop_payload_envelope && enable &&
        (cur_slot == target_slot);
    assign pos_next = (pend_reg || drop_composite_timing ||
        trib_pos == vt_drop_pkg::SF_LAST_POS) ? vt_drop_pkg::POS_V1 :
        trib_pos + 7'h01;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_cnt_reg <= 7'h00;
            pend_reg <= 1'b0;
            trib_valid <= 1'b0;
            trib_pos <= 7'h00;
        end else begin
            if (drop_payload_envelope) begin
                slot_cnt_reg <= slot_cnt_next;
            end
            pend_reg <= hit ? 1'b0 : (pend_reg || drop_composite_timing);
            trib_valid <= hit;
            if (hit) begin
                trib_pos <= pos_next;
            end
        end
    end
endmodule // vt_slot_locator

/* File: hw/vt_pointer_decode.sv */
// Purpose: Decodes one V1/V2 pointer word against the active pointer.
// Assumes: Inputs are stable for the cycle in which the word is judged.
// Notes: Purely combinational.
`timescale 1ns/10ps
module vt_pointer_decode (
    input wire logic [7:0] v1_byte,
    input wire logic [7:0] v2_byte,
    input wire logic [9:0] cur_ptr,
    output logic ndf_enabled,
    output logic ndf_normal,
    output logic size_ok,
    output logic all_ones,
    output logic in_range,
    output logic inc_vote,
    output logic dec_vote,
    output logic [9:0] rx_ptr
);
    logic [3:0] ndf;
    logic [9:0] inc_agree;
    logic [9:0] dec_agree;
    logic [3:0] inc_cnt;
    logic [3:0] dec_cnt;

    assign ndf = v1_byte[7:4];
    assign rx_ptr = {v1_byte[1:0], v2_byte};
    assign ndf_enabled = ndf == vt_drop_pkg::NDF_ENABLE ||
        ndf == vt_drop_pkg::NDF_EN_E1 || ndf == vt_drop_pkg::NDF_EN_E2 ||
        ndf == vt_drop_pkg::NDF_EN_E3;
    assign ndf_normal = ndf == vt_drop_pkg::NDF_NORMAL ||
        ndf == vt_drop_pkg::NDF_NM_E1 || ndf == vt_drop_pkg::NDF_NM_E2 ||
        ndf == vt_drop_pkg::NDF_NM_E3 || ndf == vt_drop_pkg::NDF_NM_E4;
    assign size_ok = v1_byte[3:2] == vt_drop_pkg::SIZE_EXPECTED;
    assign all_ones = &{v1_byte, v2_byte};
    assign in_range = rx_ptr <= vt_drop_pkg::PTR_MAX;
    // A bit agrees when it matches the current pointer with the voted
    // half inverted; bit errors up to two per word are tolerated.
    assign inc_agree = ~(rx_ptr ^ (cur_ptr ^ vt_drop_pkg::I_MASK));
    assign dec_agree = ~(rx_ptr ^ (cur_ptr ^ vt_drop_pkg::D_MASK));

    always_comb begin
        inc_cnt = 4'h0;
        dec_cnt = 4'h0;
        for (int i = 0; i < 10; i++) begin
            inc_cnt = inc_cnt + {3'h0, inc_agree[i]};
            dec_cnt = dec_cnt + {3'h0, dec_agree[i]};
        end
    end

    assign inc_vote = inc_cnt >= vt_drop_pkg::VOTE_MIN;
    assign dec_vote = dec_cnt >= vt_drop_pkg::VOTE_MIN;
endmodule // vt_pointer_decode

/* File: hw/vt15_pointer_tracker.sv */
// Purpose: Drop-side VT1.5/TU-11 slot selection and pointer tracking.
// Assumes: One instance per mapper channel; inputs synchronous to sys_clk.
// Notes: Register port is the channel's slice of the processor interface.
`timescale 1ns/10ps
module vt15_pointer_tracker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] drop_data,
    input wire logic drop_composite_timing,
    input wire logic drop_payload_envelope,
    input wire logic high_rate_select,
    input wire logic itu_mode_select,
    input wire logic signal_fail_input,
    input wire logic perf_tick,
    input wire logic [5:0] up_addr,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [7:0] up_wdata,
    output logic [7:0] up_rdata,
    output logic just_inc,
    output logic just_dec,
    output logic ds1_ais,
    output logic [9:0] pointer_value,
    output logic alarm_indication
);
    logic [7:0] slot_select_reg;
    logic [7:0] mask_reg;
    logic [1:0] event_reg;
    logic [1:0] perf_reg;
    logic [1:0] fault_reg;
    logic [1:0] accum_reg;
    logic [1:0] steady_reg;
    logic [1:0] status_prev_reg;
    logic [1:0] rx_size_reg;
    logic [7:0] data_d_reg;
    logic [7:0] v1_reg;
    logic trib_valid;
    logic [6:0] trib_pos;
    logic word_strobe;
    logic ndf_enabled;
    logic ndf_normal;
    logic size_ok;
    logic all_ones;
    logic in_range;
    logic inc_vote;
    logic dec_vote;
    logic [9:0] rx_ptr;
    vt_drop_pkg::ptr_state_e state_reg;
    vt_drop_pkg::ptr_state_e state_next;
    logic [9:0] ptr_reg;
    logic [9:0] ptr_next;
    logic [9:0] cand_reg;
    logic [9:0] cand_next;
    logic [1:0] new_cnt_reg;
    logic [1:0] new_cnt_next;
    logic [1:0] ones_cnt_reg;
    logic [1:0] ones_cnt_next;
    logic [3:0] inv_cnt_reg;
    logic [3:0] inv_cnt_next;
    logic [3:0] ndf_cnt_reg;
    logic [3:0] ndf_cnt_next;
    logic inc_next;
    logic dec_next;
    logic valid_word;
    logic ais_word;
    logic [1:0] status_now;
    logic [1:0] rise;
    logic [1:0] event_clear;
    logic [7:0] rdata_next;
    logic [1:0] new_inc;
    logic [9:0] ptr_up;
    logic [9:0] ptr_down;

    // Slot position: offsets after V2, V3, V4, V1 follow from byte count.
    vt_slot_locator u_locator (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .drop_composite_timing(drop_composite_timing),
        .drop_payload_envelope(drop_payload_envelope),
        .high_rate_select(high_rate_select),
        .enable(slot_select_reg[vt_drop_pkg::BIT_SLOT_VALID]),
        .slot_select(slot_select_reg[6:0]),
        .trib_valid(trib_valid),
        .trib_pos(trib_pos)
    );

    vt_pointer_decode u_decode (
        .v1_byte(v1_reg),
        .v2_byte(data_d_reg),
        .cur_ptr(ptr_reg),
        .ndf_enabled(ndf_enabled),
        .ndf_normal(ndf_normal),
        .size_ok(size_ok),
        .all_ones(all_ones),
        .in_range(in_range),
        .inc_vote(inc_vote),
        .dec_vote(dec_vote),
        .rx_ptr(rx_ptr)
    );

    assign word_strobe = trib_valid && trib_pos == vt_drop_pkg::POS_V2;
    // A justification word is out of range by nature; only NORM may take it.
    assign valid_word = size_ok && !all_ones &&
        (ndf_enabled || ndf_normal) && (in_range ||
        (state_reg == vt_drop_pkg::ST_NORM && ndf_normal &&
        (inc_vote || dec_vote)));
    assign ais_word = all_ones &&
        ones_cnt_reg == vt_drop_pkg::AIS_COUNT - 2'h1;
    assign new_inc = (rx_ptr == cand_reg) ? new_cnt_reg + 2'h1 : 2'h1;
    assign ptr_up = (ptr_reg >= vt_drop_pkg::PTR_MAX) ? 10'h000 :
        ptr_reg + 10'h001;
    assign ptr_down = (ptr_reg == 10'h000) ? vt_drop_pkg::PTR_MAX :
        ptr_reg - 10'h001;

    // One state machine per channel instance; channels never share it.
    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        cand_next = cand_reg;
        new_cnt_next = new_cnt_reg;
        inv_cnt_next = inv_cnt_reg;
        ndf_cnt_next = ndf_cnt_reg;
        ones_cnt_next = ones_cnt_reg;
        inc_next = 1'b0;
        dec_next = 1'b0;
        if (word_strobe) begin
            ones_cnt_next = (all_ones && !ais_word) ?
                ones_cnt_reg + 2'h1 : 2'h0;
            if (ais_word) begin
                state_next = vt_drop_pkg::ST_AIS;
                inv_cnt_next = 4'h0;
                new_cnt_next = 2'h0;
                ndf_cnt_next = 4'h0;
                ones_cnt_next = vt_drop_pkg::AIS_COUNT - 2'h1;
            end else if (!valid_word) begin
                new_cnt_next = 2'h0;
                ndf_cnt_next = 4'h0;
                if (inv_cnt_reg == vt_drop_pkg::LOP_COUNT - 4'h1) begin
                    // AIS holds unless ITU behaviour is selected.
                    if (state_reg != vt_drop_pkg::ST_AIS || itu_mode_select) begin
                        state_next = vt_drop_pkg::ST_LOP;
                    end
                end else begin
                    inv_cnt_next = inv_cnt_reg + 4'h1;
                end
            end else if (ndf_enabled) begin
                inv_cnt_next = 4'h0;
                new_cnt_next = 2'h0;
                ptr_next = rx_ptr;
                if (ndf_cnt_reg == vt_drop_pkg::LOP_COUNT - 4'h1) begin
                    state_next = vt_drop_pkg::ST_LOP;
                end else begin
                    ndf_cnt_next = ndf_cnt_reg + 4'h1;
                    state_next = vt_drop_pkg::ST_NORM;
                end
            end else begin
                inv_cnt_next = 4'h0;
                ndf_cnt_next = 4'h0;
                if (state_reg == vt_drop_pkg::ST_NORM && rx_ptr == ptr_reg) begin
                    new_cnt_next = 2'h0;
                end else begin
                    if (state_reg == vt_drop_pkg::ST_NORM && inc_vote) begin
                        ptr_next = ptr_up;
                        inc_next = 1'b1;
                    end else if (state_reg == vt_drop_pkg::ST_NORM && dec_vote) begin
                        ptr_next = ptr_down;
                        dec_next = 1'b1;
                    end
                    // Mimicked justifications still count as new pointers.
                    if (in_range) begin
                        cand_next = rx_ptr;
                        new_cnt_next = new_inc;
                        if (new_inc == vt_drop_pkg::NEW_COUNT) begin
                            ptr_next = rx_ptr;
                            state_next = vt_drop_pkg::ST_NORM;
                            new_cnt_next = 2'h0;
                        end
                    end else begin
                        new_cnt_next = 2'h0;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= vt_drop_pkg::ST_LOP;
            ptr_reg <= 10'h000;
            cand_reg <= 10'h000;
            new_cnt_reg <= 2'h0;
            ones_cnt_reg <= 2'h0;
            inv_cnt_reg <= 4'h0;
            ndf_cnt_reg <= 4'h0;
            just_inc <= 1'b0;
            just_dec <= 1'b0;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            cand_reg <= cand_next;
            new_cnt_reg <= new_cnt_next;
            ones_cnt_reg <= ones_cnt_next;
            inv_cnt_reg <= inv_cnt_next;
            ndf_cnt_reg <= ndf_cnt_next;
            just_inc <= inc_next;
            just_dec <= dec_next;
        end
    end

    // Capture bytes; V1 is held until the matching V2 arrives.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_d_reg <= 8'h00;
            v1_reg <= 8'h00;
            rx_size_reg <= 2'h0;
        end else begin
            data_d_reg <= drop_data;
            if (trib_valid && trib_pos == vt_drop_pkg::POS_V1) begin
                v1_reg <= data_d_reg;
                rx_size_reg <= data_d_reg[3:2];
            end
        end
    end

    // Alarm reporting; the fail input hides both pointer alarms.
    assign status_now = signal_fail_input ? 2'b00 :
        {state_reg == vt_drop_pkg::ST_AIS,
         state_reg == vt_drop_pkg::ST_LOP};
    assign rise = status_now & ~status_prev_reg;
    assign event_clear = (up_rd && up_addr == vt_drop_pkg::OFS_EVENT) ?
        event_reg : 2'b00;
    assign ds1_ais = |status_now;
    assign pointer_value = ptr_reg;
    assign alarm_indication = |(event_reg &
        ~mask_reg[vt_drop_pkg::BIT_AIS:vt_drop_pkg::BIT_LOP]);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_prev_reg <= 2'b00;
            event_reg <= 2'b00;
            perf_reg <= 2'b00;
            fault_reg <= 2'b00;
            accum_reg <= 2'b00;
            steady_reg <= 2'b11;
        end else begin
            status_prev_reg <= status_now;
            // A new edge in the read cycle survives the clear.
            event_reg <= (event_reg & ~event_clear) | rise;
            if (perf_tick) begin
                perf_reg <= accum_reg | rise;
                fault_reg <= steady_reg & status_now;
                accum_reg <= 2'b00;
                steady_reg <= 2'b11;
            end else begin
                accum_reg <= accum_reg | rise;
                steady_reg <= steady_reg & status_now;
            end
        end
    end

    // Register port: writes take effect next edge, reads answer next edge.
    always_comb begin
        case (up_addr)
            vt_drop_pkg::OFS_SLOT_SELECT: rdata_next = slot_select_reg;
            vt_drop_pkg::OFS_MASK: rdata_next = mask_reg;
            vt_drop_pkg::OFS_STATUS: rdata_next = {2'b00, status_now, 4'h0};
            vt_drop_pkg::OFS_EVENT: rdata_next = {2'b00, event_reg, 4'h0};
            vt_drop_pkg::OFS_PERF: rdata_next = {2'b00, perf_reg, 4'h0};
            vt_drop_pkg::OFS_FAULT: rdata_next = {2'b00, fault_reg, 4'h0};
            vt_drop_pkg::OFS_RX_LABEL: rdata_next = {3'b000, rx_size_reg, 3'b000};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_select_reg <= vt_drop_pkg::SLOT_SELECT_RESET;
            mask_reg <= vt_drop_pkg::MASK_RESET;
            up_rdata <= 8'h00;
        end else begin
            if (up_wr && up_addr == vt_drop_pkg::OFS_SLOT_SELECT) begin
                slot_select_reg <= up_wdata;
            end
            if (up_wr && up_addr == vt_drop_pkg::OFS_MASK) begin
                mask_reg <= up_wdata;
            end
            if (up_rd) begin
                up_rdata <= rdata_next;
            end
        end
    end

    chk_no_drop_disabled: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !slot_select_reg[vt_drop_pkg::BIT_SLOT_VALID] ##1
        !slot_select_reg[vt_drop_pkg::BIT_SLOT_VALID] |-> !trib_valid)
        else $error("Tributary byte taken while slot disabled.");

    chk_ais_needs_three: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state_reg != vt_drop_pkg::ST_AIS &&
        state_next == vt_drop_pkg::ST_AIS |-> all_ones && ones_cnt_reg == 2'h2)
        else $error("AIS entered without three all-ones pointers.");

    chk_ais_holds_gr: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state_reg == vt_drop_pkg::ST_AIS && !itu_mode_select |=>
        state_reg != vt_drop_pkg::ST_LOP)
        else $error("AIS left for LOP with ITU mode off.");

    chk_inc_step: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        inc_next && new_inc != vt_drop_pkg::NEW_COUNT |=>
        just_inc && ptr_reg == ($past(ptr_reg) == vt_drop_pkg::PTR_MAX ?
        10'h000 : $past(ptr_reg) + 10'h001))
        else $error("Increment did not step pointer by one.");

    chk_dec_step: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        dec_next && new_inc != vt_drop_pkg::NEW_COUNT |=>
        just_dec && ptr_reg == ($past(ptr_reg) == 10'h000 ?
        vt_drop_pkg::PTR_MAX : $past(ptr_reg) - 10'h001))
        else $error("Decrement did not step pointer by one.");

    chk_fail_masks: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        signal_fail_input |-> !ds1_ais && rise == 2'b00)
        else $error("Pointer alarm shown during signal fail.");

    chk_ds1_ais_or: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        !signal_fail_input && state_reg != vt_drop_pkg::ST_NORM |-> ds1_ais)
        else $error("DS1 AIS missing during pointer alarm.");

    chk_size_read: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        up_rd && up_addr == vt_drop_pkg::OFS_RX_LABEL |=>
        up_rdata[vt_drop_pkg::BIT_SIZE_HI:vt_drop_pkg::BIT_SIZE_LO] ==
        $past(rx_size_reg))
        else $error("Size bits not returned on label read.");

    chk_ptr_in_range: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        ptr_reg <= vt_drop_pkg::PTR_MAX)
        else $error("Active pointer outside legal range.");
endmodule // vt15_pointer_tracker

/* File: tb/vt_bus_source.sv */
// Purpose: Drop bus source sending one pointer word per superframe.
// Assumes: Low rate, slot 0 selected, payload envelope always high.
// Notes: Unselected bytes carry a changing pattern, never the pointer.
`timescale 1ns/10ps
module vt_bus_source (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] v1_in,
    input wire logic [7:0] v2_in,
    output logic [7:0] drop_data,
    output logic drop_composite_timing,
    output logic drop_payload_envelope
);
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic [7:0] w1_reg;
    logic [7:0] w2_reg;
    // One superframe is 108 selected bytes of 28 slots each.
    assign cnt_next = (cnt_reg == 12'hBCF) ? 12'h000 : cnt_reg + 12'h001;
    // The word is taken at the boundary so V1 and V2 never come from two
    // different words.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 12'h000;
            w1_reg <= 8'h00;
            w2_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
            if (cnt_reg == 12'hBCF) begin
                w1_reg <= v1_in;
                w2_reg <= v2_in;
            end
        end
    end
    assign drop_payload_envelope = 1'b1;
    assign drop_composite_timing = (cnt_reg == 12'h000);
    assign drop_data = (cnt_reg == 12'h000) ? w1_reg :
        (cnt_reg == 12'h2F4) ? w2_reg : cnt_reg[7:0] ^ 8'hA5;
endmodule // vt_bus_source

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the drop pointer tracker.
// Assumes: Pointer words change only at superframe starts.
// Notes: Each pointer word needs one superframe plus 800 cycles to land.
`timescale 1ns/10ps
module tb_top;
    logic sys_clk, reset_n, sfail, up_wr, up_rd, dct, dpe, inc, dec, ais;
    logic alarm, itu, tick;
    logic [5:0] up_addr;
    logic [7:0] up_wdata, up_rdata, dd, v1, v2;
    logic [9:0] pv, p;
    int errors, n_checks, incs, decs;
    vt_bus_source src (.sys_clk(sys_clk), .reset_n(reset_n), .v1_in(v1),
        .v2_in(v2), .drop_data(dd), .drop_composite_timing(dct),
        .drop_payload_envelope(dpe));
    vt15_pointer_tracker uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .drop_data(dd), .drop_composite_timing(dct),
        .drop_payload_envelope(dpe), .high_rate_select(1'b0),
        .itu_mode_select(itu), .signal_fail_input(sfail),
        .perf_tick(tick), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
        .up_wdata(up_wdata), .up_rdata(up_rdata), .just_inc(inc),
        .just_dec(dec), .ds1_ais(ais), .pointer_value(pv),
        .alarm_indication(alarm));
    task final_report;
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [9:0] g, input logic [9:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 up_addr = a;
        up_wdata = d;
        up_wr = w;
        up_rd = !w;
        @(posedge sys_clk);
        #1 up_wr = 1'b0;
        up_rd = 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({2'h0, up_rdata}, {2'h0, e});
    endtask
    task sf(input logic [7:0] a, input logic [7:0] b, input int n);
        @(posedge sys_clk);
        #1 v1 = a;
        v2 = b;
        repeat (n) @(posedge sys_clk iff dct);
    endtask
    task pulse;
        @(posedge sys_clk);
        #1 tick = 1'b1;
        @(posedge sys_clk);
        #1 tick = 1'b0;
    endtask
    task word(input logic [9:0] w, input int n);
        sf({6'h1B, w[9:8]}, w[7:0], n);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (inc === 1'b1) incs++;
        if (dec === 1'b1) decs++;
    end
    initial begin
        #(25 * 95000);
        errors++;
        final_report;
    end
    initial begin
        {reset_n, sfail, up_wr, up_rd, itu, tick} = 6'h00;
        {up_addr, up_wdata, v1, v2} = 30'h0;
        void'($urandom(32'h444F58F1));
        p = 10'($urandom % 103);
        repeat (12) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk({9'h0, ais}, 10'h001);
        rd(6'h04, 8'h00);
        word(p, 2);
        rd(6'h11, 8'h10);
        acc(1'b1, 6'h04, 8'h80);
        rd(6'h04, 8'h80);
        rd(6'h3F, 8'h00);
        word(p, 4);
        repeat (800) @(posedge sys_clk);
        rd(6'h11, 8'h00);
        chk(pv, p);
        chk({9'h0, ais}, 10'h000);
        rd(6'h20, 8'h18);
        acc(1'b0, 6'h15, 8'h00);
        word(p ^ 10'h2AA, 1);
        word(p + 10'h001, 4);
        chk(10'(incs), 10'h001);
        chk(pv, p + 10'h001);
        word((p + 10'h001) ^ 10'h156, 1);
        word(p, 2);
        repeat (800) @(posedge sys_clk);
        chk(10'(decs), 10'h001);
        chk(pv, p);
        sf(8'hFF, 8'hFF, 2);
        repeat (800) @(posedge sys_clk);
        rd(6'h11, 8'h00);
        sf(8'hFF, 8'hFF, 1);
        repeat (800) @(posedge sys_clk);
        rd(6'h11, 8'h20);
        chk({9'h0, alarm}, 10'h001);
        rd(6'h15, 8'h20);
        rd(6'h15, 8'h00);
        pulse;
        pulse;
        rd(6'h19, 8'h00);
        rd(6'h1D, 8'h20);
        @(posedge sys_clk);
        #1 sfail = 1'b1;
        #5 chk({9'h0, ais}, 10'h000);
        @(posedge sys_clk);
        #1 sfail = 1'b0;
        sf(8'h60, 8'h00, 9);
        repeat (800) @(posedge sys_clk);
        rd(6'h11, 8'h20);
        rd(6'h20, 8'h00);
        itu = 1'b1;
        sf(8'h60, 8'h00, 1);
        repeat (800) @(posedge sys_clk);
        rd(6'h11, 8'h10);
        final_report;
    end
endmodule // tb_top
